// ### rtl/brightness_pkg.sv
// shared constants and types for the one-wire brightness link
package brightness_pkg;
   localparam int CLK_MHZ = 200;
   localparam int CNT_W = 20;
   typedef logic [CNT_W-1:0] cnt_t;

   // times in microseconds
   localparam int SHUTDOWN_US = 2500;
   localparam int DET_DELAY_US = 100;
   localparam int DET_TIME_US = 260;
   localparam int DET_WIN_US = 1000;
   localparam int PHASE_MIN_US = 2;
   localparam int PHASE_MAX_US = 360;
   localparam int ACK_US = 20;
   localparam int HOST_SHDN_US = 3000;
   localparam int HOST_ENA_US = 150;
   localparam int HOST_DETLOW_US = 300;
   localparam int HOST_UNIT_US = 10;
   localparam int HOST_ACKWIN_US = 40;

   // the same times in clock cycles
   localparam cnt_t SHUTDOWN_CYC = cnt_t'(SHUTDOWN_US * CLK_MHZ);
   localparam cnt_t DET_DELAY_CYC = cnt_t'(DET_DELAY_US * CLK_MHZ);
   localparam cnt_t DET_TIME_CYC = cnt_t'(DET_TIME_US * CLK_MHZ);
   localparam cnt_t DET_WIN_CYC = cnt_t'(DET_WIN_US * CLK_MHZ);
   localparam cnt_t PHASE_MIN_CYC = cnt_t'(PHASE_MIN_US * CLK_MHZ);
   localparam cnt_t PHASE_MAX_CYC = cnt_t'(PHASE_MAX_US * CLK_MHZ);
   localparam cnt_t ACK_CYC = cnt_t'(ACK_US * CLK_MHZ);
   localparam cnt_t HOST_SHDN_CYC = cnt_t'(HOST_SHDN_US * CLK_MHZ);
   localparam cnt_t HOST_ENA_CYC = cnt_t'(HOST_ENA_US * CLK_MHZ);
   localparam cnt_t HOST_DETLOW_CYC = cnt_t'(HOST_DETLOW_US * CLK_MHZ);
   localparam cnt_t HOST_UNIT_CYC = cnt_t'(HOST_UNIT_US * CLK_MHZ);
   localparam cnt_t HOST_ACKWIN_CYC = cnt_t'(HOST_ACKWIN_US * CLK_MHZ);

   // value is arbitrary, not any real part's address
   localparam logic [7:0] DEV_ADDR = 8'h5A;

   // data byte layout
   localparam int ACK_REQ_BIT = 7;
   localparam int SUB_HI_BIT = 6;
   localparam int SUB_LO_BIT = 5;
   localparam int CODE_MSB = 4;
   localparam int CODE_LSB = 0;
   localparam logic [4:0] LAST_BIT = 5'h0F;
   localparam logic [4:0] BYTE_END_BIT = 5'h07;

   localparam logic [4:0] CODE_FULL = 5'h1F;
   localparam logic [7:0] FULL_MV = 8'hC8;
   localparam int FILT_SHIFT = 4;
   localparam logic [15:0] FILT_STEP = {FULL_MV, 8'h00} >> FILT_SHIFT;

   // code to millivolt segments
   localparam logic [9:0] SEG1_END = 10'h00C;
   localparam logic [9:0] SEG2_END = 10'h017;
   localparam logic [9:0] STEP1 = 10'h003;
   localparam logic [9:0] STEP2 = 10'h006;
   localparam logic [9:0] STEP3 = 10'h00C;
   localparam logic [9:0] OFS1 = 10'h002;
   localparam logic [9:0] OFS2 = 10'h022;
   localparam logic [9:0] OFS3 = 10'h0AC;

   typedef enum logic [3:0] {
      ST_OFF = 4'h1,
      ST_DETECT = 4'h2,
      ST_PWM = 4'h4,
      ST_SERIAL = 4'h8
   } mode_t;

   function automatic logic [7:0] level_mv(input logic [4:0] code);
      logic [9:0] c;
      logic [9:0] r;
      c = {5'h00, code};
      if (c == 10'h000) r = 10'h000;
      else if (c <= SEG1_END) r = STEP1 * c + OFS1;
      else if (c <= SEG2_END) r = STEP2 * c - OFS2;
      else r = STEP3 * c - OFS3;
      return r[7:0];
   endfunction : level_mv
endpackage : brightness_pkg

// ### rtl/ctrl_link_if.sv
// control pin shared by host and device, resolved with a pull-up
`timescale 1ns/100ps
interface ctrl_link_if;
   logic host_out;
   logic host_oe_n;
   logic dev_out;
   logic dev_oe_n;
   logic line;

   // device only ever pulls low; a released line floats high on the pull-up
   assign line = (!dev_oe_n && !dev_out) ? 1'b0 : (!host_oe_n ? host_out : 1'b1);

   modport host (input line, output host_out, output host_oe_n);
   modport device (input line, output dev_out, output dev_oe_n);
endinterface : ctrl_link_if

// ### rtl/bit_phase_decoder.sv
// measures high and low phases of the pin and classifies each bit
`timescale 1ns/100ps
module bit_phase_decoder
   import brightness_pkg::*;
#(
   parameter cnt_t PHASE_MAX_CYC_P = PHASE_MAX_CYC
)(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pin
   input wire logic line_i,
   // bit results
   output logic bit_stb_o,
   output logic bit_val_o,
   output logic bit_bad_o,
   output logic rise_o
);
   logic line_d_ff;
   cnt_t hi_cnt_ff;
   cnt_t lo_cnt_ff;
   logic [CNT_W:0] hi2;
   logic [CNT_W:0] lo2;
   logic fall;
   logic is_one;
   logic is_zero;
   logic out_range;

   assign fall = line_d_ff && !line_i;
   assign hi2 = {hi_cnt_ff, 1'b0};
   assign lo2 = {lo_cnt_ff, 1'b0};
   // ratio compare keeps decoding independent of bit rate
   assign is_one = {1'b0, hi_cnt_ff} >= lo2;
   assign is_zero = {1'b0, lo_cnt_ff} >= hi2;
   assign out_range = hi_cnt_ff < PHASE_MIN_CYC || lo_cnt_ff < PHASE_MIN_CYC
                      || hi_cnt_ff > PHASE_MAX_CYC_P || lo_cnt_ff > PHASE_MAX_CYC_P;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_d_ff <= 1'b1;
         hi_cnt_ff <= '0;
         lo_cnt_ff <= '0;
         bit_stb_o <= 1'b0;
         bit_val_o <= 1'b0;
         bit_bad_o <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         line_d_ff <= line_i;
         rise_o <= line_i && !line_d_ff;
         bit_stb_o <= fall;
         if (fall) begin
            bit_val_o <= is_one;
            bit_bad_o <= out_range || !(is_one || is_zero);
         end
         if (line_i && !line_d_ff) hi_cnt_ff <= cnt_t'(1);
         else if (line_i && hi_cnt_ff != '1) hi_cnt_ff <= hi_cnt_ff + cnt_t'(1);
         if (fall) lo_cnt_ff <= cnt_t'(1);
         else if (!line_i && lo_cnt_ff != '1) lo_cnt_ff <= lo_cnt_ff + cnt_t'(1);
      end
   end
endmodule : bit_phase_decoder

// ### rtl/brightness_device.sv
// one-wire brightness control: device end behind the control pin
`timescale 1ns/100ps
module brightness_device
   import brightness_pkg::*;
#(
   parameter cnt_t SHUTDOWN_CYC_P = SHUTDOWN_CYC,
   parameter cnt_t DET_DELAY_CYC_P = DET_DELAY_CYC,
   parameter cnt_t DET_TIME_CYC_P = DET_TIME_CYC,
   parameter cnt_t DET_WIN_CYC_P = DET_WIN_CYC,
   parameter cnt_t PHASE_MAX_CYC_P = PHASE_MAX_CYC
)(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // protection indications
   input wire logic uvlo_i,
   input wire logic overtemp_i,
   // control pin
   ctrl_link_if.device link,
   // regulation outputs
   output logic switch_en_o,
   output logic [7:0] feedback_reference_level_o,
   output logic serial_mode_o,
   output logic [4:0] level_code_o
);
   mode_t state_ff;
   mode_t nxt_state;
   cnt_t low_cnt_ff;
   cnt_t win_cnt_ff;
   cnt_t ack_cnt_ff;
   cnt_t nxt_ack_cnt;
   logic [15:0] filt_ff;
   logic [15:0] nxt_filt;
   logic [15:0] shift_ff;
   logic [4:0] bit_cnt_ff;
   logic [1:0] skip_ff;
   logic bad_ff;
   logic ack_pend_ff;
   logic ack_oe_n_ff;

   logic line;
   logic fault;
   logic long_low;
   logic det_ok;
   logic in_serial;
   logic bit_stb;
   logic bit_val;
   logic bit_bad;
   logic rise;
   logic take_bit;
   logic frame_end;
   logic byte_end;
   logic frame_ok;
   logic level_wr;
   logic ack_start;
   logic [15:0] frame;
   logic [7:0] ref_sel;

   bit_phase_decoder #(
      .PHASE_MAX_CYC_P(PHASE_MAX_CYC_P)
   ) u_dec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .line_i(line),
      .bit_stb_o(bit_stb),
      .bit_val_o(bit_val),
      .bit_bad_o(bit_bad),
      .rise_o(rise)
   );

   assign line = link.line;
   assign link.dev_out = 1'b0;
   assign link.dev_oe_n = ack_oe_n_ff;

   assign fault = uvlo_i | overtemp_i;
   assign long_low = low_cnt_ff > SHUTDOWN_CYC_P;
   // the low phase must start after the detection delay and outlast the detect time
   assign det_ok = low_cnt_ff > DET_TIME_CYC_P
                   && (win_cnt_ff - low_cnt_ff) >= DET_DELAY_CYC_P;
   assign in_serial = state_ff == ST_SERIAL;

   // receive path: one strobe after each byte is end-of-stream plus start, dropped
   assign take_bit = in_serial && bit_stb && skip_ff == 2'h0;
   assign frame = {shift_ff[14:0], bit_val};
   assign frame_end = take_bit && bit_cnt_ff == LAST_BIT;
   assign byte_end = take_bit && (bit_cnt_ff == BYTE_END_BIT || frame_end);
   assign frame_ok = frame_end && !bad_ff && !bit_bad && frame[15:8] == DEV_ADDR;
   assign level_wr = frame_ok && !frame[SUB_HI_BIT] && !frame[SUB_LO_BIT];
   assign ack_start = in_serial && ack_pend_ff && rise;

   assign nxt_ack_cnt = ack_start ? ACK_CYC
                      : (ack_cnt_ff != '0 ? ack_cnt_ff - cnt_t'(1) : ack_cnt_ff);

   // chopped reference into a first-order low pass; settles to duty times full scale
   assign nxt_filt = filt_ff - (filt_ff >> FILT_SHIFT) + (line ? FILT_STEP : 16'h0000);

   assign ref_sel = (state_ff == ST_OFF) ? 8'h00
                  : in_serial ? level_mv(level_code_o)
                  : filt_ff[15:8];

   always_comb begin
      nxt_state = state_ff;
      if (fault || long_low) begin
         nxt_state = ST_OFF;
      end else begin
         unique case (state_ff)
            ST_OFF: begin
               if (line) nxt_state = ST_DETECT;
            end
            ST_DETECT: begin
               if (det_ok) nxt_state = ST_SERIAL;
               else if (win_cnt_ff >= DET_WIN_CYC_P) nxt_state = ST_PWM;
            end
            ST_PWM, ST_SERIAL: begin
               nxt_state = state_ff;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_OFF;
         low_cnt_ff <= '0;
         win_cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         if (line) low_cnt_ff <= '0;
         else if (low_cnt_ff != '1) low_cnt_ff <= low_cnt_ff + cnt_t'(1);
         if (state_ff != ST_DETECT) win_cnt_ff <= '0;
         else if (win_cnt_ff != '1) win_cnt_ff <= win_cnt_ff + cnt_t'(1);
      end
   end

   // level register survives shutdown but every new enable restarts at full scale
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_code_o <= CODE_FULL;
      end else if (state_ff == ST_OFF && nxt_state == ST_DETECT) begin
         level_code_o <= CODE_FULL;
      end else if (level_wr) begin
         level_code_o <= frame[CODE_MSB:CODE_LSB];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !in_serial) begin
         shift_ff <= '0;
         bit_cnt_ff <= '0;
         skip_ff <= 2'h1;
         bad_ff <= 1'b0;
      end else if (ack_start) begin
         skip_ff <= 2'h2;
      end else if (bit_stb && skip_ff != 2'h0) begin
         skip_ff <= skip_ff - 2'h1;
      end else if (take_bit) begin
         shift_ff <= frame;
         bit_cnt_ff <= frame_end ? 5'h00 : bit_cnt_ff + 5'h01;
         bad_ff <= frame_end ? 1'b0 : (bad_ff | bit_bad);
         if (byte_end) skip_ff <= 2'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !in_serial) begin
         ack_pend_ff <= 1'b0;
      end else if (frame_end) begin
         ack_pend_ff <= frame_ok && frame[ACK_REQ_BIT];
      end else if (ack_start) begin
         ack_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !in_serial) begin
         ack_cnt_ff <= '0;
         ack_oe_n_ff <= 1'b1;
      end else begin
         ack_cnt_ff <= nxt_ack_cnt;
         ack_oe_n_ff <= nxt_ack_cnt == '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || nxt_state == ST_OFF) begin
         filt_ff <= '0;
      end else if (nxt_state != ST_SERIAL) begin
         filt_ff <= nxt_filt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         switch_en_o <= 1'b0;
         serial_mode_o <= 1'b0;
         feedback_reference_level_o <= 8'h00;
      end else begin
         switch_en_o <= nxt_state != ST_OFF;
         serial_mode_o <= in_serial;
         feedback_reference_level_o <= ref_sel;
      end
   end
endmodule : brightness_device

// ### rtl/brightness_host.sv
// one-wire brightness control: host end driving the control pin
`timescale 1ns/100ps
module brightness_host
   import brightness_pkg::*;
#(
   parameter cnt_t SHDN_CYC_P = HOST_SHDN_CYC,
   parameter cnt_t ENA_CYC_P = HOST_ENA_CYC,
   parameter cnt_t DETLOW_CYC_P = HOST_DETLOW_CYC,
   parameter cnt_t UNIT_CYC_P = HOST_UNIT_CYC,
   parameter cnt_t ACKWIN_CYC_P = HOST_ACKWIN_CYC
)(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // user commands
   input wire logic select_serial_i,
   input wire logic send_i,
   input wire logic [4:0] code_i,
   input wire logic [1:0] sub_i,
   input wire logic ack_req_i,
   // user status
   output logic busy_o,
   output logic done_o,
   output logic ack_seen_o,
   // control pin
   ctrl_link_if.host link
);
   typedef enum logic [8:0] {
      H_IDLE = 9'h001,
      H_SHDN = 9'h002,
      H_ENA = 9'h004,
      H_DETLOW = 9'h008,
      H_START = 9'h010,
      H_BLOW = 9'h020,
      H_BHIGH = 9'h040,
      H_EOS = 9'h080,
      H_ACKWIN = 9'h100
   } hstate_t;

   hstate_t state_ff;
   cnt_t tmr_ff;
   logic [15:0] frame_ff;
   logic [3:0] idx_ff;
   logic ack_req_ff;
   logic out_ff;
   logic oe_n_ff;
   logic tdone;
   logic bit_now;
   cnt_t long_t;
   cnt_t low_t;
   cnt_t high_t;

   assign link.host_out = out_ff;
   assign link.host_oe_n = oe_n_ff;
   assign tdone = tmr_ff == '0;
   assign bit_now = frame_ff[15];
   // three units against one keeps the 2:1 phase ratio with margin
   assign long_t = cnt_t'(UNIT_CYC_P * 3);
   assign low_t = bit_now ? UNIT_CYC_P : long_t;
   assign high_t = bit_now ? long_t : UNIT_CYC_P;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= H_IDLE;
         tmr_ff <= '0;
         frame_ff <= '0;
         idx_ff <= '0;
         ack_req_ff <= 1'b0;
         out_ff <= 1'b1;
         oe_n_ff <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         ack_seen_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (!tdone) tmr_ff <= tmr_ff - cnt_t'(1);
         unique case (state_ff)
            H_IDLE: begin
               if (select_serial_i) begin
                  state_ff <= H_SHDN;
                  tmr_ff <= SHDN_CYC_P;
                  out_ff <= 1'b0;
                  busy_o <= 1'b1;
               end else if (send_i) begin
                  state_ff <= H_START;
                  tmr_ff <= UNIT_CYC_P;
                  frame_ff <= {DEV_ADDR, ack_req_i, sub_i, code_i};
                  ack_req_ff <= ack_req_i;
                  idx_ff <= '0;
                  ack_seen_o <= 1'b0;
                  busy_o <= 1'b1;
               end
            end
            H_SHDN: if (tdone) begin
               state_ff <= H_ENA;
               tmr_ff <= ENA_CYC_P;
               out_ff <= 1'b1;
            end
            H_ENA: if (tdone) begin
               state_ff <= H_DETLOW;
               tmr_ff <= DETLOW_CYC_P;
               out_ff <= 1'b0;
            end
            H_START: if (tdone) begin
               state_ff <= H_BLOW;
               tmr_ff <= low_t;
               out_ff <= 1'b0;
            end
            H_BLOW: if (tdone) begin
               state_ff <= H_BHIGH;
               tmr_ff <= high_t;
               out_ff <= 1'b1;
            end
            H_BHIGH: if (tdone) begin
               frame_ff <= {frame_ff[14:0], 1'b0};
               idx_ff <= idx_ff + 4'h1;
               out_ff <= 1'b0;
               state_ff <= (idx_ff == 4'h7 || idx_ff == 4'hF) ? H_EOS : H_BLOW;
               tmr_ff <= (idx_ff == 4'h7 || idx_ff == 4'hF) ? UNIT_CYC_P : frame_ff[14] ? UNIT_CYC_P : long_t;
            end
            H_EOS: if (tdone) begin
               out_ff <= 1'b1;
               if (idx_ff == 4'h8) begin
                  state_ff <= H_START;
                  tmr_ff <= UNIT_CYC_P;
               end else if (ack_req_ff) begin
                  state_ff <= H_ACKWIN;
                  tmr_ff <= ACKWIN_CYC_P;
                  oe_n_ff <= 1'b1;
               end else begin
                  state_ff <= H_IDLE;
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
               end
            end
            H_DETLOW, H_ACKWIN: begin
               if (state_ff == H_ACKWIN && !link.line) ack_seen_o <= 1'b1;
               if (tdone) begin
                  state_ff <= H_IDLE;
                  out_ff <= 1'b1;
                  oe_n_ff <= 1'b0;
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
               end
            end
         endcase
      end
   end
endmodule : brightness_host

// ### bench/brightness_link_properties.sv
// concurrent checks on the shared control pin and the device outputs
`timescale 1ns/100ps
module brightness_link_properties
   import brightness_pkg::*;
#(
   parameter int SHDN_P = 2000
)(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // protection indications
   input wire logic uvlo_i,
   input wire logic overtemp_i,
   // control pin
   input wire logic host_out,
   input wire logic host_oe_n,
   input wire logic dev_out,
   input wire logic dev_oe_n,
   input wire logic line,
   // device outputs
   input wire logic switch_en_o,
   input wire logic [7:0] feedback_reference_level_o,
   input wire logic serial_mode_o,
   input wire logic [4:0] level_code_o
);
   localparam int ACK_LEN = int'(ACK_CYC);
   int low_ff;
   int on_ff;
   int ack_ff;
   logic [4:0] code_q_ff;
   logic [4:0] code_qq_ff;
   logic ser_q_ff;
   logic ser_qq_ff;

   // own copy of the table, so a slip in the shared function is not masked
   function automatic logic [7:0] table_mv(input logic [4:0] c);
      logic [9:0] w;
      w = {5'h00, c};
      if (w == 10'h000) return 8'h00;
      if (w <= 10'h00C) return 8'(10'h003 * w + 10'h002);
      if (w <= 10'h017) return 8'(10'h006 * w - 10'h022);
      return 8'(10'h00C * w - 10'h0AC);
   endfunction : table_mv

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_ff <= 0;
         on_ff <= 0;
         ack_ff <= 0;
         code_q_ff <= CODE_FULL;
         code_qq_ff <= CODE_FULL;
         ser_q_ff <= 1'b0;
         ser_qq_ff <= 1'b0;
      end else begin
         low_ff <= line ? 0 : low_ff + 1;
         on_ff <= (switch_en_o && line) ? on_ff + 1 : 0;
         ack_ff <= dev_oe_n ? 0 : ack_ff + 1;
         code_q_ff <= level_code_o;
         code_qq_ff <= code_q_ff;
         ser_q_ff <= serial_mode_o;
         ser_qq_ff <= ser_q_ff;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // small margins absorb the one-cycle lag of the helper counter
   sequence s_long_low;
      low_ff > SHDN_P + 4;
   endsequence
   sequence s_ack_start;
      $fell(dev_oe_n);
   endsequence

   a_long_low_off: assert property (s_long_low |-> !switch_en_o)
      else $error("switch still running after long low pin");
   a_no_early_off: assert property ($fell(switch_en_o) && !$past(uvlo_i) && !$past(overtemp_i) |-> low_ff >= SHDN_P - 4)
      else $error("switch stopped without cause");
   a_uvlo_holds_off: assert property (uvlo_i |=> !switch_en_o)
      else $error("switch running under undervoltage");
   a_hot_holds_off: assert property (overtemp_i |=> !switch_en_o)
      else $error("switch running under overtemperature");
   a_steady_full: assert property (!serial_mode_o && on_ff > 400 |-> feedback_reference_level_o == FULL_MV)
      else $error("steady high pin not at full reference");
   a_code_table: assert property (serial_mode_o && ser_qq_ff && level_code_o == code_q_ff && code_q_ff == code_qq_ff
      |-> feedback_reference_level_o == table_mv(level_code_o))
      else $error("serial reference does not match code");
   a_enable_full: assert property ($rose(switch_en_o) |-> ##1 level_code_o == CODE_FULL)
      else $error("enable did not restore full level");
   a_mode_fixed: assert property ($fell(serial_mode_o) |-> !switch_en_o)
      else $error("mode left while running");
   a_ack_drain: assert property (!dev_oe_n |-> serial_mode_o && !dev_out)
      else $error("device drives pin outside serial acknowledge");
   a_no_clash: assert property (!dev_oe_n |-> host_oe_n)
      else $error("host drives pin during acknowledge");
   a_ack_len: assert property (ack_ff <= ACK_LEN)
      else $error("acknowledge held too long");
   a_ack_after_rise: assert property (s_ack_start |-> $past(line))
      else $error("acknowledge started while pin low");
endmodule : brightness_link_properties

// ### bench/one_wire_brightness_control_tb.sv
// self-checking bench: host and device ends joined over the control pin
`timescale 1ns/100ps
module one_wire_brightness_control_tb
   import brightness_pkg::*;
();
   // shutdown must outlast the fixed 4000-cycle acknowledge low, or the ack itself would shut the device down
   localparam cnt_t DEV_SHDN = 20'h01770;
   localparam cnt_t DET_DLY = 20'h000C8;
   localparam cnt_t DET_TM = 20'h00208;
   localparam cnt_t DET_WN = 20'h007D0;
   localparam cnt_t PH_MAX = 20'h00578;
   // host shutdown low must exceed the device shutdown time
   localparam cnt_t HOST_OFF = 20'h01F40;
   localparam cnt_t HOST_ON = 20'h0012C;
   localparam cnt_t HOST_DLOW = 20'h002BC;
   localparam cnt_t HOST_AWIN = 20'h01388;
   localparam cnt_t UNIT = 20'h001C2;
   localparam int UNIT_I = int'(UNIT);
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic uvlo_i = 1'b0;
   logic overtemp_i = 1'b0;
   logic select_serial_i = 1'b0;
   logic send_i = 1'b0;
   logic [4:0] code_i = 5'h00;
   logic [1:0] sub_i = 2'h0;
   logic ack_req_i = 1'b0;
   logic switch_en_o;
   logic [7:0] ref_mv;
   logic serial_mode_o;
   logic [4:0] level_code_o;
   logic busy_o;
   logic done_o;
   logic ack_seen_o;
   int err_total = 0;
   int n_checks = 0;
   logic line_q_ff = 1'b1;
   int lo_n = 0;
   int hi_n = 0;
   int wire_cnt = 0;
   logic [15:0] wire_bits = 16'h0000;

   ctrl_link_if ctrl_link_if_i ();
   brightness_device #(.SHUTDOWN_CYC_P(DEV_SHDN), .DET_DELAY_CYC_P(DET_DLY), .DET_TIME_CYC_P(DET_TM),
      .DET_WIN_CYC_P(DET_WN), .PHASE_MAX_CYC_P(PH_MAX)) brightness_device_i (
      .clk_i(clk_i), .rst_i(rst_i), .uvlo_i(uvlo_i), .overtemp_i(overtemp_i), .link(ctrl_link_if_i),
      .switch_en_o(switch_en_o), .feedback_reference_level_o(ref_mv), .serial_mode_o(serial_mode_o),
      .level_code_o(level_code_o));
   brightness_host #(.SHDN_CYC_P(HOST_OFF), .ENA_CYC_P(HOST_ON), .DETLOW_CYC_P(HOST_DLOW), .UNIT_CYC_P(UNIT),
      .ACKWIN_CYC_P(HOST_AWIN)) brightness_host_i (
      .clk_i(clk_i), .rst_i(rst_i), .select_serial_i(select_serial_i), .send_i(send_i), .code_i(code_i),
      .sub_i(sub_i), .ack_req_i(ack_req_i), .busy_o(busy_o), .done_o(done_o), .ack_seen_o(ack_seen_o),
      .link(ctrl_link_if_i));
   brightness_link_properties #(.SHDN_P(int'(DEV_SHDN))) brightness_link_properties_i (
      .clk_i(clk_i), .rst_i(rst_i), .uvlo_i(uvlo_i), .overtemp_i(overtemp_i),
      .host_out(ctrl_link_if_i.host_out), .host_oe_n(ctrl_link_if_i.host_oe_n), .dev_out(ctrl_link_if_i.dev_out),
      .dev_oe_n(ctrl_link_if_i.dev_oe_n), .line(ctrl_link_if_i.line), .switch_en_o(switch_en_o),
      .feedback_reference_level_o(ref_mv), .serial_mode_o(serial_mode_o), .level_code_o(level_code_o));

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   // wire-side decoder: only phases within the bit range and at a 2:1 ratio count, so idle, byte strobes and ack are skipped
   always @(posedge clk_i) begin
      line_q_ff <= ctrl_link_if_i.line;
      if (ctrl_link_if_i.line) begin
         hi_n <= line_q_ff ? hi_n + 1 : 1;
      end else begin
         lo_n <= line_q_ff ? 1 : lo_n + 1;
      end
      if (send_i) begin
         wire_cnt <= 0;
      end else if (line_q_ff && !ctrl_link_if_i.line && hi_n > UNIT_I / 2 && lo_n > UNIT_I / 2
                   && hi_n < 4 * UNIT_I && lo_n < 4 * UNIT_I && (hi_n >= 2 * lo_n || lo_n >= 2 * hi_n)) begin
         wire_bits <= {wire_bits[14:0], hi_n > lo_n};
         wire_cnt <= wire_cnt + 1;
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wait_done();
      int k;
      k = 0;
      while (done_o !== 1'b1 && k < 40000) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 40000) begin
         err_total++;
         $display("Error done expected 1 seen timeout");
         summarize();
      end
   endtask : wait_done

   task automatic send_frame(input logic [4:0] code, input logic [1:0] sub, input logic req);
      @(posedge clk_i);
      send_i <= 1'b1;
      code_i <= code;
      sub_i <= sub;
      ack_req_i <= req;
      @(posedge clk_i);
      send_i <= 1'b0;
      wait_done();
      chk("busy after done", 16'h0000, 16'(busy_o));
   endtask : send_frame

   initial begin
      repeat (95000) @(posedge clk_i);
      err_total++;
      $display("Error watchdog expected finish seen timeout");
      summarize();
   end

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("level after reset", 16'h001F, 16'(level_code_o));
      repeat (2500) @(posedge clk_i);
      chk("pwm default", 16'h0000, 16'(serial_mode_o));
      chk("switch on", 16'h0001, 16'(switch_en_o));
      chk("steady high ref", 16'h00C8, 16'(ref_mv));
      $display("test pwm_default finished");
      select_serial_i <= 1'b1;
      @(posedge clk_i);
      select_serial_i <= 1'b0;
      repeat (7000) @(posedge clk_i);
      chk("long low shutdown", 16'h0000, 16'(switch_en_o));
      wait_done();
      chk("serial selected", 16'h0001, 16'(serial_mode_o));
      chk("full level on enable", 16'h001F, 16'(level_code_o));
      chk("full ref in serial", 16'h00C8, 16'(ref_mv));
      $display("test serial_select finished");
      send_frame(5'h0C, 2'h1, 1'b1);
      chk("wire bit count", 16'h0010, 16'(wire_cnt));
      chk("wire frame", {DEV_ADDR, 1'b1, 2'h1, 5'h0C}, wire_bits);
      chk("ack seen", 16'h0001, 16'(ack_seen_o));
      chk("level kept on subaddress", 16'h001F, 16'(level_code_o));
      send_frame(5'h18, 2'h0, 1'b0);
      chk("wire frame", {DEV_ADDR, 1'b0, 2'h0, 5'h18}, wire_bits);
      chk("no ack unrequested", 16'h0000, 16'(ack_seen_o));
      chk("level updated", 16'h0018, 16'(level_code_o));
      chk("table ref", 16'h0074, 16'(ref_mv));
      $display("test serial_frames finished");
      for (int i = 0; i < 2; i++) begin
         uvlo_i <= (i == 0);
         overtemp_i <= (i == 1);
         repeat (4) @(posedge clk_i);
         chk("protect off", 16'h0000, 16'(switch_en_o));
         chk("mode dropped", 16'h0000, 16'(serial_mode_o));
         uvlo_i <= 1'b0;
         overtemp_i <= 1'b0;
         repeat (2500) @(posedge clk_i);
         chk("restart", 16'h0001, 16'(switch_en_o));
         chk("restart level", 16'h001F, 16'(level_code_o));
      end
      $display("test protection finished");
      summarize();
   end
endmodule : one_wire_brightness_control_tb
